// File: asw_host.sv
module asw_host #(
    parameter int STORE_WAIT = asw_pkg::STORE_CYC            // Longest store wait, cycles
) (
    input  wire logic                  mclk,                 // System clock
    input  wire logic                  rstn,                 // Async reset, active low
    input  wire logic                  cmd_valid,            // Command request
    input  wire logic [1:0]            cmd_op,               // Command code
    input  wire logic [asw_pkg::AW-1:0] cmd_addr,            // Word address
    input  wire logic [asw_pkg::DW-1:0] cmd_wdata,           // Write data
    output logic                       cmd_ready,            // Command taken when high
    output logic                       rsp_valid,            // Completion pulse
    output logic [asw_pkg::DW-1:0]     rsp_rdata,            // Read data
    output logic                       rsp_err,              // Store never finished
    output logic                       ce1_n,                // Chip enable one, low active
    output logic                       ce2,                  // Chip enable two, high active
    output logic                       oe_n,                 // Output enable, low active
    output logic                       we_n,                 // Write enable, low active
    output logic                       bhe_n,                // Upper byte enable
    output logic                       ble_n,                // Lower byte enable
    output logic [asw_pkg::AW-1:0]     mem_addr,             // Device address
    output logic [asw_pkg::DW-1:0]     dq_o,                 // Data out
    output logic                       dq_oe,                // Data drive enable
    input  wire logic [asw_pkg::DW-1:0] dq_i,                // Data in
    input  wire logic                  save_busy_n           // Device busy, low active
);
    // ***************************************************************
    // State
    // ***************************************************************
    typedef struct packed {
        asw_pkg::asw_state_t       st;                       // Sequencer state
        logic [asw_pkg::CW-1:0]    cnt;                      // Phase counter
        logic [3:0]                step;                     // Read index in command
        logic                      seq;                      // Mode command in flight
        logic [1:0]                op;                       // Latched command code
        logic                      cmd_ready;
        logic                      rsp_valid;
        logic [asw_pkg::DW-1:0]    rsp_rdata;
        logic                      rsp_err;
        logic                      ce1_n;
        logic                      ce2;
        logic                      oe_n;
        logic                      we_n;
        logic                      bhe_n;                    // Upper byte enable, held low
        logic                      ble_n;                    // Lower byte enable, held low
        logic [asw_pkg::AW-1:0]    mem_addr;
        logic [asw_pkg::DW-1:0]    dq_o;
        logic                      dq_oe;
    } asw_host_t;

    asw_host_t                 s;                            // Registered state
    asw_host_t                 next_s;                       // Next state
    logic [asw_pkg::DW-1:0]    dq_sync;                      // Synchronised data pins
    logic                      busy_n;                       // Synchronised busy pin

    // ***************************************************************
    // Pin synchronisers
    // ***************************************************************
    asw_sync #(.W(asw_pkg::DW), .RST('0)) u_dq_sync (
        .mclk (mclk),
        .rstn (rstn),
        .din  (dq_i),
        .dout (dq_sync)
    );
    asw_sync #(.W(1), .RST(1'b1)) u_busy_sync (
        .mclk (mclk),
        .rstn (rstn),
        .din  (save_busy_n),
        .dout (busy_n)
    );

    // Address of a read within a command; upper lines stay zero
    function automatic logic [asw_pkg::AW-1:0] seq_addr(input logic [3:0] step, input logic [1:0] op);
        logic [3:0]  idx;
        logic [15:0] a;
        idx = (step < asw_pkg::SEQ_LEN) ? step : step - asw_pkg::SEQ_LEN;
        case (idx)
            4'h0: a = asw_pkg::PFX0;
            4'h1: a = asw_pkg::PFX1;
            4'h2: a = asw_pkg::PFX2;
            4'h3: a = asw_pkg::PFX3;
            4'h4: a = asw_pkg::PFX4;
            default: begin
                if (step >= asw_pkg::SEQ_LEN) begin
                    a = asw_pkg::ADR_STO;
                end else if (op == asw_pkg::OP_AS_OFF) begin
                    a = asw_pkg::ADR_DIS;
                end else begin
                    a = asw_pkg::ADR_EN;
                end
            end
        endcase
        seq_addr = {4'h0, a};
    endfunction

    // ***************************************************************
    // Sequencer
    // ***************************************************************
    // All pin strobes come from the state register, so pins never glitch
    always_comb begin
        next_s           = s;
        next_s.rsp_valid = 1'b0;
        case (s.st)
            asw_pkg::ST_IDLE: begin
                next_s.cmd_ready = busy_n;                   // Hold off while device busy
                if (cmd_valid && s.cmd_ready && busy_n) begin
                    next_s.cmd_ready = 1'b0;
                    next_s.op      = cmd_op;
                    next_s.rsp_err = 1'b0;
                    next_s.step    = 4'h0;
                    next_s.seq     = cmd_op[1];
                    next_s.ce1_n   = 1'b0;
                    next_s.ce2     = 1'b1;
                    next_s.st      = asw_pkg::ST_ACC;
                    if (cmd_op == asw_pkg::OP_WRITE) begin
                        next_s.mem_addr = cmd_addr;
                        next_s.dq_o     = cmd_wdata;
                        next_s.dq_oe    = 1'b1;
                        next_s.we_n     = 1'b0;
                        next_s.cnt      = asw_pkg::CW'(asw_pkg::WR_CYC - 1);
                    end else begin
                        next_s.mem_addr = cmd_op[1] ? seq_addr(4'h0, cmd_op) : cmd_addr;
                        next_s.oe_n     = 1'b0;
                        next_s.cnt      = asw_pkg::CW'(asw_pkg::RD_CYC - 1);
                    end
                end
            end
            asw_pkg::ST_ACC: begin
                // Chip enable frames each access, giving chip-enable controlled reads
                if (s.cnt == '0) begin
                    next_s.rsp_rdata = s.op == asw_pkg::OP_READ ? dq_sync : s.rsp_rdata;
                    next_s.ce1_n = 1'b1;
                    next_s.ce2   = 1'b0;
                    next_s.oe_n  = 1'b1;
                    next_s.we_n  = 1'b1;
                    next_s.dq_oe = 1'b0;
                    next_s.st    = asw_pkg::ST_RECOV;
                end else begin
                    next_s.cnt = s.cnt - 1'b1;
                end
            end
            asw_pkg::ST_RECOV: begin
                if (s.seq && s.step != asw_pkg::LAST_STEP) begin
                    // Next read of the command; write enable never drops
                    next_s.step     = s.step + 4'h1;
                    next_s.mem_addr = seq_addr(s.step + 4'h1, s.op);
                    next_s.ce1_n    = 1'b0;
                    next_s.ce2      = 1'b1;
                    next_s.oe_n     = 1'b0;
                    next_s.cnt      = asw_pkg::CW'(asw_pkg::RD_CYC - 1);
                    next_s.st       = asw_pkg::ST_ACC;
                end else if (s.seq) begin
                    next_s.cnt = asw_pkg::CW'(asw_pkg::BST_CYC - 1);
                    next_s.st  = asw_pkg::ST_BUSYLO;
                end else begin
                    next_s.rsp_valid = 1'b1;
                    next_s.st        = asw_pkg::ST_IDLE;
                end
            end
            asw_pkg::ST_BUSYLO: begin
                // Device may skip the store; give up waiting after a bound
                if (!busy_n) begin
                    next_s.cnt = asw_pkg::CW'(STORE_WAIT - 1);
                    next_s.st  = asw_pkg::ST_BUSYHI;
                end else if (s.cnt == '0) begin
                    next_s.cnt = asw_pkg::CW'(asw_pkg::LZ_CYC - 1);
                    next_s.st  = asw_pkg::ST_SETTLE;
                end else begin
                    next_s.cnt = s.cnt - 1'b1;
                end
            end
            asw_pkg::ST_BUSYHI: begin
                if (busy_n || s.cnt == '0) begin
                    next_s.rsp_err = !busy_n;
                    next_s.cnt     = asw_pkg::CW'(asw_pkg::LZ_CYC - 1);
                    next_s.st      = asw_pkg::ST_SETTLE;
                end else begin
                    next_s.cnt = s.cnt - 1'b1;
                end
            end
            asw_pkg::ST_SETTLE: begin
                // Array stays blocked a while after busy releases
                if (s.cnt == '0) begin
                    next_s.seq       = 1'b0;
                    next_s.rsp_valid = 1'b1;
                    next_s.st        = asw_pkg::ST_IDLE;
                end else begin
                    next_s.cnt = s.cnt - 1'b1;
                end
            end
            default: begin
                next_s.st = asw_pkg::ST_IDLE;
            end
        endcase
    end

    // State register; chip deselected, strobes and data drive released in reset, byte enables low
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s       <= '0;
            s.st    <= asw_pkg::ST_IDLE;
            s.ce1_n <= 1'b1;
            s.oe_n  <= 1'b1;
            s.we_n  <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ***************************************************************
    // Outputs
    // ***************************************************************
    assign cmd_ready = s.cmd_ready;
    assign rsp_valid = s.rsp_valid;
    assign rsp_rdata = s.rsp_rdata;
    assign rsp_err   = s.rsp_err;
    assign ce1_n     = s.ce1_n;
    assign ce2       = s.ce2;
    assign oe_n      = s.oe_n;
    assign we_n      = s.we_n;
    assign bhe_n     = s.bhe_n;
    assign ble_n     = s.ble_n;
    assign mem_addr  = s.mem_addr;
    assign dq_o      = s.dq_o;
    assign dq_oe     = s.dq_oe;

    // ***************************************************************
    // Checks
    // ***************************************************************
    AST_DIS_ADDR: assert property (@(posedge mclk) disable iff (!rstn)
        $fell(ce1_n) && s.seq && s.step == 4'h5 && s.op == asw_pkg::OP_AS_OFF |-> mem_addr == 20'h08b45)
        else $error("Sixth read of off command has wrong address");
    AST_EN_ADDR: assert property (@(posedge mclk) disable iff (!rstn)
        $fell(ce1_n) && s.seq && s.step == 4'h5 && s.op == asw_pkg::OP_AS_ON |-> mem_addr == 20'h04b46)
        else $error("Sixth read of on command has wrong address");
    AST_PREFIX: assert property (@(posedge mclk) disable iff (!rstn)
        $fell(ce1_n) && s.seq && s.step == 4'h1 |-> mem_addr == 20'h0b1c7 && $past(mem_addr, 1 + asw_pkg::RD_CYC) == 20'h04e38)
        else $error("Prefix order broken");
    AST_CE_FRAME: assert property (@(posedge mclk) disable iff (!rstn)
        $fell(ce1_n) && we_n |-> !ce1_n && !oe_n [*8] ##1 ce1_n && oe_n)
        else $error("Read not framed by chip enable");
    AST_STORE_FOLLOWS: assert property (@(posedge mclk) disable iff (!rstn)
        $fell(ce1_n) && s.seq && s.step == 4'hb |-> mem_addr == 20'h08fc0)
        else $error("Mode change not followed by save");
    AST_NO_INTRUDE: assert property (@(posedge mclk) disable iff (!rstn)
        s.seq |-> !cmd_ready && !dq_oe)
        else $error("Access accepted inside a sequence");
    AST_WE_HIGH: assert property (@(posedge mclk) disable iff (!rstn)
        s.seq && !ce1_n |-> we_n && !oe_n)
        else $error("Write enable low during sequence read");
    AST_UPPER_ZERO: assert property (@(posedge mclk) disable iff (!rstn)
        s.seq && !ce1_n |-> mem_addr[19:16] == 4'h0)
        else $error("Upper address lines not zero in sequence");
    AST_SELECT: assert property (@(posedge mclk) disable iff (!rstn)
        ce2 == !ce1_n)
        else $error("Chip enables disagree");
endmodule

// File: asw_pkg.sv
package asw_pkg;
    // ***************************************************************
    // Pin timing and clock rate
    // ***************************************************************
    localparam int CLK_PERIOD_NS = 10;                       // Clock period of mclk
    localparam int T_RC_NS       = 45;                       // Read cycle time, slow grade
    localparam int T_WC_NS       = 45;                       // Write cycle time, slow grade
    localparam int T_STORE_MS    = 8;                        // Longest store duration
    localparam int T_LZ_BUSY_NS  = 5000;                     // Busy release to output active
    localparam int T_BUSY_ST_NS  = 1000;                     // Wait for busy to start
    localparam int SYNC_LAT      = 3;                        // Cycles allowed for the three-stage pin synchroniser
    // Least times round up
    localparam int RD_CYC   = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LAT;
    localparam int WR_CYC   = (T_WC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LZ_CYC   = (T_LZ_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BST_CYC  = (T_BUSY_ST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STORE_CYC = T_STORE_MS * 1000000 / CLK_PERIOD_NS;

    // ***************************************************************
    // Widths and command addresses
    // ***************************************************************
    localparam int AW  = 20;                                 // Device address width
    localparam int DW  = 16;                                 // Device data width
    localparam int CW  = 20;                                 // Counter width
    localparam logic [15:0] PFX0     = 16'h4e38;             // Sequence prefix, first
    localparam logic [15:0] PFX1     = 16'hb1c7;             // Sequence prefix, second
    localparam logic [15:0] PFX2     = 16'h83e0;             // Sequence prefix, third
    localparam logic [15:0] PFX3     = 16'h7c1f;             // Sequence prefix, fourth
    localparam logic [15:0] PFX4     = 16'h703f;             // Sequence prefix, fifth
    localparam logic [15:0] ADR_DIS  = 16'h8b45;             // Autosave off, sixth
    localparam logic [15:0] ADR_EN   = 16'h4b46;             // Autosave on, sixth
    localparam logic [15:0] ADR_STO  = 16'h8fc0;             // Software save, sixth
    localparam logic [3:0]  LAST_STEP = 4'hb;                // Twelve reads per command
    localparam logic [3:0]  SEQ_LEN   = 4'h6;                // Reads per sequence

    // ***************************************************************
    // Host command codes
    // ***************************************************************
    localparam logic [1:0] OP_READ  = 2'h0;                  // Plain array read
    localparam logic [1:0] OP_WRITE = 2'h1;                  // Plain array write
    localparam logic [1:0] OP_AS_OFF = 2'h2;                 // Turn autosave off
    localparam logic [1:0] OP_AS_ON  = 2'h3;                 // Turn autosave on

    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_ACC    = 6'h02,
        ST_RECOV  = 6'h04,
        ST_BUSYLO = 6'h08,
        ST_BUSYHI = 6'h10,
        ST_SETTLE = 6'h20
    } asw_state_t;
endpackage

// File: asw_sync.sv
// Three-stage pin synchroniser; a bit changes once stages two and three agree
module asw_sync #(
    parameter int            W   = 1,                        // Number of bits
    parameter logic [W-1:0]  RST = '0                        // Reset level
) (
    input  wire logic         mclk,                          // System clock
    input  wire logic         rstn,                          // Async reset, active low
    input  wire logic [W-1:0] din,                           // Pin level
    output logic      [W-1:0] dout                           // Filtered level
);
    // ***************************************************************
    // Per-bit chain
    // ***************************************************************
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1;                                        // Read only by s2
            logic s2;                                        // Second stage
            logic s3;                                        // Third stage
            // Output only moves on agreement, so a metastable settle is ignored
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    s1      <= RST[i];
                    s2      <= RST[i];
                    s3      <= RST[i];
                    dout[i] <= RST[i];
                end else begin
                    s1 <= din[i];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3) begin
                        dout[i] <= s3;
                    end
                end
            end
        end
    endgenerate
endmodule

// File: asw_dev_model.sv
// Behavioural model of the memory device facing the host controller
module asw_dev_model #(
    parameter int BUSY_LEN = 40                                  // Store duration in mclk cycles
) (
    input  wire logic        mclk,                               // Sampling clock of the model
    input  wire logic        ce1_n,                              // Chip enable one, low active
    input  wire logic        ce2,                                // Chip enable two, high active
    input  wire logic        oe_n,                               // Output enable, low active
    input  wire logic        we_n,                               // Write enable, low active
    input  wire logic [19:0] mem_addr,                           // Address pins
    input  wire logic [15:0] dq_in,                              // Data seen on the pins
    input  wire logic        vlow,                               // Core supply below switch level
    input  wire logic        hang,                               // Holds busy low until cleared
    output logic      [15:0] dq_out,                             // Data driven by the device
    output logic             save_busy_n,                        // Busy pin, pulled up when idle
    output logic             autosave,                           // Power-down autosave flag
    output int               store_cnt,                          // Stores started
    output int               wr_cnt                              // Writes seen on the pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // ***************************************************************
    // State
    // ***************************************************************
    logic [15:0] mem [0:255];                                    // Small array, low address bits
    logic [15:0] last = 16'h0000;                                // Last driven data word
    logic [15:0] seq [0:4] = '{16'h4e38, 16'hb1c7, 16'h83e0, 16'h7c1f, 16'h703f};
    logic        p_sel = 1'b0;                                   // Select one sample ago
    logic        p_we = 1'b1;                                    // Write enable one sample ago
    logic        p_vlow = 1'b0;                                  // Supply flag one sample ago
    logic        held_wr = 1'b0;                                 // Write held through power-up
    logic [19:0] p_adr = 20'h00000;                              // Address one sample ago
    logic [15:0] p_dq = 16'h0000;                                // Data one sample ago
    int          step = 0;                                       // Prefix reads matched
    int          busy = 0;                                       // Store cycles left
    wire         sel = !ce1_n && ce2;
    initial begin
        autosave = 1'b1;
        store_cnt = 0;
        wr_cnt = 0;
        foreach (mem[i]) mem[i] = 16'h0000;
    end
    // Released bus shows a changing pattern, never the last word
    assign dq_out = (sel && !oe_n && we_n) ? mem[mem_addr[7:0]] : ~last;
    assign save_busy_n = (busy == 0);
    // ***************************************************************
    // Access end detection and sequence decoding
    // ***************************************************************
    // Acting at the end of the select window avoids racing the host's own edge
    always @(posedge mclk) begin
        last <= dq_out;
        if (p_sel && !sel && !p_we) begin
            wr_cnt <= wr_cnt + 1;
            step <= 0;
            if (!vlow && busy == 0 && !held_wr) mem[p_adr[7:0]] <= p_dq;
        end else if (p_sel && !sel && p_we) begin
            if (step < 5) begin
                step <= (p_adr[14:2] == seq[step][14:2]) ? step + 1 : 0;
            end else begin
                step <= 0;
                if (p_adr[14:2] == 13'h02d1) autosave <= 1'b0;
                if (p_adr[14:2] == 13'h12d1) autosave <= 1'b1;
                // Low supply blocks the requested save outright
                if (p_adr[14:2] == 13'h03f0 && !vlow) begin
                    busy <= BUSY_LEN;
                    store_cnt <= store_cnt + 1;
                end
            end
        end
        // Supply drop saves the array only while autosave is on
        if (vlow && !p_vlow && autosave && busy == 0) begin
            busy <= BUSY_LEN;
            store_cnt <= store_cnt + 1;
        end
        if (busy > 1 || (busy == 1 && !hang)) busy <= busy - 1;
        // A write already selected while supply is low is dropped at its end
        held_wr <= (vlow && sel && !we_n) || (held_wr && sel);
        p_vlow <= vlow;
        p_sel <= sel;
        p_we <= we_n;
        p_adr <= mem_addr;
        p_dq <= dq_in;
    end
endmodule

// File: test_power_down_autosave_mode_and_write_guard.sv
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module test_power_down_autosave_mode_and_write_guard;
    timeunit 1ns;
    timeprecision 1ps;
    // ***************************************************************
    // Signals
    // ***************************************************************
    logic        mclk = 1'b0;                                    // 100 MHz clock
    logic        rstn = 1'b0;                                    // Reset, low active
    logic        cmd_valid = 1'b0;                               // Host request
    logic [1:0]  cmd_op = 2'h0;                                  // Host command
    logic [19:0] cmd_addr = 20'h00000;                           // Host address
    logic [15:0] cmd_wdata = 16'h0000;                           // Host write data
    logic        vlow = 1'b0;                                    // Low supply flag
    logic        hang = 1'b0;                                    // Stuck busy flag
    logic        cmd_ready, rsp_valid, rsp_err, ce1_n, ce2, oe_n, we_n, dq_oe, busy_n, autosave;
    logic        bhe_n, ble_n;                                   // Byte enables
    logic [15:0] rsp_rdata, dq_o, dev_dq;
    logic [19:0] mem_addr;
    int          store_cnt, wr_cnt;
    int          fail_count = 0;                                 // Mismatches
    int          checks = 0;                                     // Comparisons
    // Pin level: host drive wins while enabled
    wire  [15:0] dq = dq_oe ? dq_o : dev_dq;
    always #5 mclk = ~mclk;
    asw_host #(.STORE_WAIT(200)) u_dut (.mclk(mclk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_err(rsp_err), .ce1_n(ce1_n), .ce2(ce2), .oe_n(oe_n), .we_n(we_n),
        .bhe_n(bhe_n), .ble_n(ble_n), .mem_addr(mem_addr), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq),
        .save_busy_n(busy_n));
    asw_dev_model u_dev (.mclk(mclk), .ce1_n(ce1_n), .ce2(ce2), .oe_n(oe_n), .we_n(we_n),
        .mem_addr(mem_addr), .dq_in(dq), .vlow(vlow), .hang(hang), .dq_out(dev_dq),
        .save_busy_n(busy_n), .autosave(autosave), .store_cnt(store_cnt), .wr_cnt(wr_cnt));
    // ***************************************************************
    // Shared tasks
    // ***************************************************************
    task automatic test_done();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Issue one command and wait for its completion pulse, both bounded
    task automatic do_cmd(input logic [1:0] op, input logic [19:0] a, input logic [15:0] d);
        int n;
        cmd_op = op;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_valid = 1'b1;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 2000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        @(posedge mclk);
        #1;
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 4000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (rsp_valid !== 1'b1) begin
            fail_count++;
            test_done();
        end
    endtask
    // ***************************************************************
    // Scenarios
    // ***************************************************************
    task automatic t_reset();
        `CHK({ce1_n, ce2, we_n, dq_oe, cmd_ready}, 5'b10100)
        `CHK(autosave, 1'b1)
        rstn = 1'b1;
        do_cmd(2'h0, 20'h00077, 16'h0000);
        `CHK(rsp_rdata, 16'h0000)
        $display("test reset done");
    endtask
    task automatic t_rw();
        do_cmd(2'h1, 20'h00012, 16'ha5c3);
        do_cmd(2'h1, 20'hfff34, 16'h5a3c);
        do_cmd(2'h0, 20'h00012, 16'h0000);
        `CHK(rsp_rdata, 16'ha5c3)
        do_cmd(2'h0, 20'hfff34, 16'h0000);
        `CHK(rsp_rdata, 16'h5a3c)
        `CHK({bhe_n, ble_n}, 2'b00)
        $display("test write read done");
    endtask
    // Mode change, with its trailing save and no writes on the pins
    task automatic t_mode(input logic [1:0] op, input logic exp);
        int s0;
        int w0;
        s0 = store_cnt;
        w0 = wr_cnt;
        do_cmd(op, 20'h00000, 16'h0000);
        `CHK(autosave, exp)
        `CHK(store_cnt, s0 + 1)
        `CHK(wr_cnt, w0)
        `CHK(rsp_err, 1'b0)
        do_cmd(2'h0, 20'h00012, 16'h0000);
        `CHK(rsp_rdata, 16'ha5c3)
        $display("test mode %0d done", op);
    endtask
    // Low supply: one power-down save while autosave is on, then write and save dropped
    task automatic t_lowv();
        int s0;
        s0 = store_cnt;
        vlow = 1'b1;
        do_cmd(2'h1, 20'h00012, 16'hffff);
        do_cmd(2'h2, 20'h00000, 16'h0000);
        `CHK(store_cnt, s0 + 1)
        `CHK(rsp_err, 1'b0)
        vlow = 1'b0;
        @(posedge mclk);
        #1;
        vlow = 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        `CHK(store_cnt, s0 + 1)
        vlow = 1'b0;
        do_cmd(2'h0, 20'h00012, 16'h0000);
        `CHK(rsp_rdata, 16'ha5c3)
        $display("test low supply done");
    endtask
    // Busy never released within the wait limit
    task automatic t_hang();
        hang = 1'b1;
        do_cmd(2'h3, 20'h00000, 16'h0000);
        `CHK(rsp_err, 1'b1)
        hang = 1'b0;
        do_cmd(2'h0, 20'hfff34, 16'h0000);
        `CHK(rsp_rdata, 16'h5a3c)
        `CHK(rsp_err, 1'b0)
        $display("test stuck busy done");
    endtask
    // ***************************************************************
    // Main sequence
    // ***************************************************************
    initial begin
        repeat (8) @(posedge mclk);
        #1;
        t_reset();
        t_rw();
        t_mode(2'h2, 1'b0);
        t_mode(2'h3, 1'b1);
        t_lowv();
        t_hang();
        test_done();
    end
endmodule
